//--- hw/acg_top.sv
// clock source selection, derived clocks and loop configuration with its register file
`include "acg_regs.svh"
`default_nettype none
module acg_top #(
	parameter int SYSCLK_HZ = 12288000,
	parameter int TO_PERIOD = SYSCLK_HZ / `ACG_TO_SLOW_HZ,
	parameter int REF_LOSS_CYCLES = 1024
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic mclk_in,
	input wire logic bclk_in,
	input wire logic lrclk_in,
	input wire logic fll_clk_in,
	output logic system_clock,
	output logic processing_clock,
	output logic timeout_clock,
	output logic mclk_out,
	output logic mclk_out_en,
	output logic loop_reference,
	output logic loop_enable_out,
	output logic loop_running,
	output logic [9:0] loop_multiplier_integer,
	output logic [15:0] loop_multiplier_fraction,
	output logic [4:0] loop_ratio_value,
	output logic [8:0] loop_output_divide,
	output logic [3:0] loop_control_divide,
	output logic [8:0] loop_error_gain_value,
	output logic [10:0] sysclk_ratio_value,
	output logic [16:0] sample_rate_hz,
	output logic sample_rate_reserved
);
	localparam int TW = 24;
	localparam logic [TW-1:0] TO_PERIOD_W = TW'(TO_PERIOD);
	localparam logic [15:0] LOSS_W = 16'(REF_LOSS_CYCLES);

	// ************************************************************
	// register file
	// ************************************************************
	acg_pkg::acg_word_t dividers_reg, rate_reg, source_reg, loop_en_reg;
	acg_pkg::acg_word_t loop_div_reg, loop_frac_reg, loop_int_reg, loop_ref_reg;

	// masked writes keep reserved bits at zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dividers_reg <= `ACG_RST_DIVIDERS;
			rate_reg <= `ACG_RST_RATE;
			source_reg <= `ACG_RST_SOURCE;
			loop_en_reg <= `ACG_RST_LOOP_EN;
			loop_div_reg <= `ACG_RST_LOOP_DIV;
			loop_frac_reg <= `ACG_RST_LOOP_FRAC;
			loop_int_reg <= `ACG_RST_LOOP_INT;
			loop_ref_reg <= `ACG_RST_LOOP_REF;
		end else if (ce && reg_wr) begin
			if (reg_addr == `ACG_OFS_DIVIDERS) begin
				dividers_reg <= reg_wdata & `ACG_MSK_DIVIDERS;
			end else if (reg_addr == `ACG_OFS_RATE) begin
				rate_reg <= reg_wdata & `ACG_MSK_RATE;
			end else if (reg_addr == `ACG_OFS_SOURCE) begin
				source_reg <= reg_wdata & `ACG_MSK_SOURCE;
			end else if (reg_addr == `ACG_OFS_LOOP_EN) begin
				loop_en_reg <= reg_wdata & `ACG_MSK_LOOP_EN;
			end else if (reg_addr == `ACG_OFS_LOOP_DIV) begin
				loop_div_reg <= reg_wdata & `ACG_MSK_LOOP_DIV;
			end else if (reg_addr == `ACG_OFS_LOOP_FRAC) begin
				loop_frac_reg <= reg_wdata & `ACG_MSK_LOOP_FRAC;
			end else if (reg_addr == `ACG_OFS_LOOP_INT) begin
				loop_int_reg <= reg_wdata & `ACG_MSK_LOOP_INT;
			end else if (reg_addr == `ACG_OFS_LOOP_REF) begin
				loop_ref_reg <= reg_wdata & `ACG_MSK_LOOP_REF;
			end
		end
	end

	// read data is registered and holds until the next read; unmapped reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
		end else if (ce && reg_rd) begin
			if (reg_addr == `ACG_OFS_DIVIDERS) begin
				reg_rdata <= dividers_reg;
			end else if (reg_addr == `ACG_OFS_RATE) begin
				reg_rdata <= rate_reg;
			end else if (reg_addr == `ACG_OFS_SOURCE) begin
				reg_rdata <= source_reg;
			end else if (reg_addr == `ACG_OFS_LOOP_EN) begin
				reg_rdata <= loop_en_reg;
			end else if (reg_addr == `ACG_OFS_LOOP_DIV) begin
				reg_rdata <= loop_div_reg;
			end else if (reg_addr == `ACG_OFS_LOOP_FRAC) begin
				reg_rdata <= loop_frac_reg;
			end else if (reg_addr == `ACG_OFS_LOOP_INT) begin
				reg_rdata <= loop_int_reg;
			end else if (reg_addr == `ACG_OFS_LOOP_REF) begin
				reg_rdata <= loop_ref_reg;
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ************************************************************
	// system clock and processing clock
	// ************************************************************
	logic sys_next;
	logic sys_rise;

	// source switch is not glitch-safe; software gates it off first
	assign sys_next = (source_reg[`ACG_B_SRC] ? fll_clk_in : mclk_in)
		& source_reg[`ACG_B_SYS_ENA];
	assign sys_rise = sys_next & ~system_clock;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			system_clock <= 1'b0;
			processing_clock <= 1'b0;
		end else if (ce) begin
			system_clock <= sys_next;
			processing_clock <= sys_next & source_reg[`ACG_B_DSP_ENA];
		end
	end

	// ************************************************************
	// timeout clock and output clock
	// ************************************************************
	logic to_div;
	logic op_div;
	logic [4:0] op_period;
	logic [TW-1:0] to_period;

	// faster select halves the period of sysclk edges
	assign to_period = TO_PERIOD_W >> dividers_reg[`ACG_F_TO_SEL];

	acg_clkdiv #(.W(TW)) u_to_div (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.clr(!source_reg[`ACG_B_TO_ENA]),
		.tick(sys_rise),
		.period(to_period),
		.div_out(to_div)
	);

	// output clock divide table
	always_comb begin
		case (dividers_reg[`ACG_F_OP_DIV])
			3'h0: op_period = 5'h01;
			3'h1: op_period = 5'h02;
			3'h2: op_period = 5'h03;
			3'h3: op_period = 5'h04;
			3'h4: op_period = 5'h06;
			3'h5: op_period = 5'h08;
			3'h6: op_period = 5'h0c;
			default: op_period = 5'h10;
		endcase
	end

	acg_clkdiv #(.W(5)) u_op_div (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.clr(!source_reg[`ACG_B_OP_ENA]),
		.tick(sys_rise),
		.period(op_period),
		.div_out(op_div)
	);

	// pin driven whenever enabled; keeping it off an input pin is software's job
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timeout_clock <= 1'b0;
			mclk_out <= 1'b0;
			mclk_out_en <= 1'b0;
		end else if (ce) begin
			timeout_clock <= to_div & source_reg[`ACG_B_TO_ENA];
			mclk_out_en <= source_reg[`ACG_B_OP_ENA];
			mclk_out <= source_reg[`ACG_B_OP_ENA]
				& ((op_period == 5'h01) ? sys_next : op_div);
		end
	end

	// ************************************************************
	// loop reference selection and division
	// ************************************************************
	logic ref_lvl;
	logic ref_q;
	logic ref_div;
	logic [3:0] ref_period;
	logic [15:0] loss_cnt_reg;

	// reserved source code gives a dead reference
	always_comb begin
		case (loop_ref_reg[`ACG_F_REF_SRC])
			2'h0: ref_lvl = bclk_in;
			2'h1: ref_lvl = mclk_in;
			2'h2: ref_lvl = lrclk_in;
			default: ref_lvl = 1'b0;
		endcase
		ref_period = 4'h1 << loop_ref_reg[`ACG_F_REF_DIV];
	end

	acg_clkdiv #(.W(4)) u_ref_div (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.clr(1'b0),
		.tick(ref_lvl & ~ref_q),
		.period(ref_period),
		.div_out(ref_div)
	);

	// reference edges restart the loss counter, which saturates
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ref_q <= 1'b0;
			loop_reference <= 1'b0;
			loss_cnt_reg <= 16'h0000;
		end else if (ce) begin
			ref_q <= ref_lvl;
			loop_reference <= (ref_period == 4'h1) ? ref_lvl : ref_div;
			if (ref_lvl & ~ref_q) begin
				loss_cnt_reg <= 16'h0000;
			end else if (loss_cnt_reg != LOSS_W) begin
				loss_cnt_reg <= loss_cnt_reg + 16'h0001;
			end
		end
	end

	// ************************************************************
	// loop state
	// ************************************************************
	acg_pkg::acg_loop_state_t loop_state_reg, loop_state_next;
	logic ref_lost;

	assign ref_lost = (loss_cnt_reg == LOSS_W);

	// clearing the enable always returns to off, which is the loop reset
	always_comb begin
		loop_state_next = loop_state_reg;
		case (loop_state_reg)
			acg_pkg::ACG_LOOP_OFF: begin
				if (loop_en_reg[`ACG_B_LOOP_ENA] && !ref_lost) begin
					loop_state_next = acg_pkg::ACG_LOOP_TRACK;
				end
			end
			acg_pkg::ACG_LOOP_TRACK: begin
				if (ref_lost) begin
					loop_state_next = loop_en_reg[`ACG_B_HOLD] ? acg_pkg::ACG_LOOP_HOLD
						: acg_pkg::ACG_LOOP_LOST;
				end
			end
			acg_pkg::ACG_LOOP_HOLD, acg_pkg::ACG_LOOP_LOST: begin
				if (!ref_lost) begin
					loop_state_next = acg_pkg::ACG_LOOP_TRACK;
				end else if (loop_state_reg == acg_pkg::ACG_LOOP_HOLD
					&& !loop_en_reg[`ACG_B_HOLD]) begin
					loop_state_next = acg_pkg::ACG_LOOP_LOST;
				end
			end
			default: loop_state_next = acg_pkg::ACG_LOOP_OFF;
		endcase
		if (!loop_en_reg[`ACG_B_LOOP_ENA]) begin
			loop_state_next = acg_pkg::ACG_LOOP_OFF;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loop_state_reg <= acg_pkg::ACG_LOOP_OFF;
			loop_running <= 1'b0;
			loop_enable_out <= 1'b0;
		end else if (ce) begin
			loop_state_reg <= loop_state_next;
			loop_enable_out <= loop_en_reg[`ACG_B_LOOP_ENA];
			loop_running <= (loop_state_reg == acg_pkg::ACG_LOOP_TRACK)
				|| (loop_state_reg == acg_pkg::ACG_LOOP_HOLD);
		end
	end

	// ************************************************************
	// decoded configuration outputs
	// ************************************************************
	logic [10:0] ratio_dec;
	logic [16:0] rate_dec;

	always_comb begin
		case (rate_reg[`ACG_F_RATIO])
			4'h0: ratio_dec = 11'd64;
			4'h1: ratio_dec = 11'd128;
			4'h2: ratio_dec = 11'd192;
			4'h3: ratio_dec = 11'd256;
			4'h4: ratio_dec = 11'd384;
			4'h5: ratio_dec = 11'd512;
			4'h6: ratio_dec = 11'd768;
			4'h7: ratio_dec = 11'd1024;
			4'h8: ratio_dec = 11'd1408;
			4'h9: ratio_dec = 11'd1536;
			default: ratio_dec = 11'd0;
		endcase
		case (rate_reg[`ACG_F_RATE])
			4'h0: rate_dec = 17'd8000;
			4'h1: rate_dec = 17'd11025;
			4'h2: rate_dec = 17'd12000;
			4'h3: rate_dec = 17'd16000;
			4'h4: rate_dec = 17'd22050;
			4'h5: rate_dec = 17'd24000;
			4'h6: rate_dec = 17'd32000;
			4'h7: rate_dec = 17'd44100;
			4'h8: rate_dec = 17'd48000;
			4'h9: rate_dec = 17'd88200;
			4'ha: rate_dec = 17'd96000;
			default: rate_dec = 17'd0;
		endcase
	end

	// gain codes above 8 saturate at the largest gain
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sysclk_ratio_value <= 11'h000;
			sample_rate_hz <= 17'h00000;
			sample_rate_reserved <= 1'b0;
			loop_multiplier_integer <= 10'h000;
			loop_multiplier_fraction <= 16'h0000;
			loop_ratio_value <= 5'h00;
			loop_output_divide <= 9'h000;
			loop_control_divide <= 4'h0;
			loop_error_gain_value <= 9'h000;
		end else if (ce) begin
			sysclk_ratio_value <= ratio_dec;
			sample_rate_hz <= rate_dec;
			sample_rate_reserved <= (rate_reg[`ACG_F_RATE] > 4'ha);
			loop_multiplier_integer <= loop_int_reg[`ACG_F_MULT_INT];
			loop_multiplier_fraction <= loop_en_reg[`ACG_B_FRAC]
				? loop_frac_reg : 16'h0000;
			loop_ratio_value <= loop_div_reg[2] ? 5'h10
				: (5'h01 << loop_div_reg[1:0]);
			loop_output_divide <= 9'h002 << loop_div_reg[`ACG_F_OUTDIV];
			loop_control_divide <= {1'b0, loop_div_reg[`ACG_F_CTRL_RATE]} + 4'h1;
			loop_error_gain_value <= (loop_int_reg[`ACG_F_GAIN] > 4'h8) ? 9'h100
				: (9'h001 << loop_int_reg[`ACG_F_GAIN]);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_ratio_top: assert property ((ce && rate_reg[7:4] == 4'h9)
		|=> sysclk_ratio_value == 11'd1536) else $error("ratio code 9 not 1536");
	chk_rate_reserved: assert property ((ce && rate_reg[3:0] == 4'hb)
		|=> sample_rate_reserved && sample_rate_hz == 17'd0)
		else $error("reserved rate not flagged");
	chk_source_loop: assert property ((ce && source_reg[13] && source_reg[0])
		|=> system_clock == $past(fll_clk_in)) else $error("loop source not used");
	chk_sys_gated: assert property ((ce && !source_reg[0])
		|=> !system_clock && !processing_clock) else $error("clock not gated");
	chk_timeout_off: assert property ((ce && !source_reg[2]) [*2]
		|=> !timeout_clock) else $error("timeout clock runs disabled");
	chk_pin_drive: assert property (ce |=> mclk_out_en == $past(source_reg[5]))
		else $error("pin enable wrong");
	chk_frac_gate: assert property ((ce && !loop_en_reg[2])
		|=> loop_multiplier_fraction == 16'h0000) else $error("fraction leaks");
	chk_ratio_sixteen: assert property ((ce && loop_div_reg[2])
		|=> loop_ratio_value == 5'd16) else $error("ratio 1XX not 16");
	chk_outdiv_max: assert property ((ce && loop_div_reg[10:8] == 3'h7)
		|=> loop_output_divide == 9'd256) else $error("outdiv 7 not 256");
	chk_gain_max: assert property ((ce && loop_int_reg[3:0] == 4'h8)
		|=> loop_error_gain_value == 9'd256) else $error("gain 8 not 256");
	chk_hold_runs: assert property ((ce && loop_state_reg == acg_pkg::ACG_LOOP_HOLD)
		|=> loop_running) else $error("held loop stopped");

	cov_loop_hold: cover property (loop_state_reg == acg_pkg::ACG_LOOP_HOLD);
	cov_pin_clock: cover property (mclk_out_en && mclk_out);
	cov_timeout_edge: cover property (timeout_clock && source_reg[9:8] == 2'h3);
endmodule
`default_nettype wire

//--- hw/acg_regs.svh
// register offsets, field positions, reset values and timing figures of the clock generator
`ifndef ACG_REGS_SVH
`define ACG_REGS_SVH

// register offsets on the control port
`define ACG_OFS_DIVIDERS 7'h0c
`define ACG_OFS_RATE 7'h0d
`define ACG_OFS_SOURCE 7'h0e
`define ACG_OFS_LOOP_EN 7'h10
`define ACG_OFS_LOOP_DIV 7'h11
`define ACG_OFS_LOOP_FRAC 7'h12
`define ACG_OFS_LOOP_INT 7'h13
`define ACG_OFS_LOOP_REF 7'h14

// writable bit masks, other bits read as zero
`define ACG_MSK_DIVIDERS 16'h1f00
`define ACG_MSK_RATE 16'h00ff
`define ACG_MSK_SOURCE 16'h2027
`define ACG_MSK_LOOP_EN 16'h000d
`define ACG_MSK_LOOP_DIV 16'h0777
`define ACG_MSK_LOOP_FRAC 16'hffff
`define ACG_MSK_LOOP_INT 16'h7fef
`define ACG_MSK_LOOP_REF 16'h001b

// reset values
`define ACG_RST_DIVIDERS 16'h0000
`define ACG_RST_RATE 16'h0038
`define ACG_RST_SOURCE 16'h0000
`define ACG_RST_LOOP_EN 16'h0000
`define ACG_RST_LOOP_DIV 16'h0200
`define ACG_RST_LOOP_FRAC 16'h0000
`define ACG_RST_LOOP_INT 16'h0204
`define ACG_RST_LOOP_REF 16'h0000

// field positions
`define ACG_F_OP_DIV 12:10
`define ACG_F_TO_SEL 9:8
`define ACG_F_RATIO 7:4
`define ACG_F_RATE 3:0
`define ACG_B_SRC 13
`define ACG_B_OP_ENA 5
`define ACG_B_TO_ENA 2
`define ACG_B_DSP_ENA 1
`define ACG_B_SYS_ENA 0
`define ACG_B_HOLD 3
`define ACG_B_FRAC 2
`define ACG_B_LOOP_ENA 0
`define ACG_F_OUTDIV 10:8
`define ACG_F_CTRL_RATE 6:4
`define ACG_F_LOOP_RATIO 2:0
`define ACG_F_MULT_INT 14:5
`define ACG_F_GAIN 3:0
`define ACG_F_REF_DIV 4:3
`define ACG_F_REF_SRC 1:0

// timing: slowest timeout clock rate in Hz
`define ACG_TO_SLOW_HZ 125

`endif

//--- hw/acg_pkg.sv
// types shared by the clock generator
`default_nettype none
package acg_pkg;
	typedef enum logic [1:0] {
		ACG_LOOP_OFF,
		ACG_LOOP_TRACK,
		ACG_LOOP_HOLD,
		ACG_LOOP_LOST
	} acg_loop_state_t;
	typedef logic [15:0] acg_word_t;
endpackage
`default_nettype wire

//--- hw/acg_clkdiv.sv
// programmable edge counter that turns source rising edges into a divided level
`default_nettype none
module acg_clkdiv #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic clr,
	input wire logic tick,
	input wire logic [W-1:0] period,
	output logic div_out
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// wrap at period; output high for the lower half of the count
	always_comb begin
		cnt_next = (cnt_reg >= period - W'(1)) ? '0 : cnt_reg + W'(1);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			div_out <= 1'b0;
		end else if (ce) begin
			if (clr) begin
				cnt_reg <= '0;
				div_out <= 1'b0;
			end else if (tick) begin
				cnt_reg <= cnt_next;
				div_out <= (cnt_next < (period >> 1));
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/acg_ref_model.sv
// reference clock sources that stand at the clock generator pins
`default_nettype none
module acg_ref_model (
	input wire logic clk,
	input wire logic stop,
	input wire logic mclk_out,
	input wire logic mclk_out_en,
	output logic mclk_in,
	output logic bclk_in,
	output logic lrclk_in,
	output logic fll_clk_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int tick = 0;
	logic mclk_src;
	// free-running phase count, moved on the falling edge away from sampling
	always @(negedge clk) begin
		tick <= tick + 1;
	end
	// mclk and bclk references are slow against the 13.5 MHz limit only after a divide of 2 or more; lrclk is slow undivided
	assign mclk_src = stop ? 1'b0 : ((tick % 6) < 3);
	assign bclk_in = stop ? 1'b0 : tick[2];
	assign lrclk_in = stop ? 1'b0 : tick[4];
	assign fll_clk_in = tick[1]; // loop oscillator keeps running
	// pin released to the generator while it drives the output clock
	assign mclk_in = mclk_out_en ? mclk_out : mclk_src;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the clock generator register file and derived clocks
`include "acg_regs.svh"
`default_nettype none
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin failures++; \
	$display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [3:0] id; logic [16:0] exp;} acg_note_t;
	// ****************************************
	// signals and tables
	// ****************************************
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stop = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, loop_multiplier_fraction;
	logic mclk_in, bclk_in, lrclk_in, fll_clk_in, system_clock, processing_clock;
	logic timeout_clock, mclk_out, mclk_out_en, loop_reference, loop_enable_out;
	logic loop_running, sample_rate_reserved, note_req = 1'b0, pend = 1'b0, in_range = 1'b0;
	logic [9:0] loop_multiplier_integer;
	logic [4:0] loop_ratio_value;
	logic [8:0] loop_output_divide, loop_error_gain_value;
	logic [3:0] loop_control_divide;
	logic [10:0] sysclk_ratio_value;
	logic [16:0] sample_rate_hz;
	int failures = 0, checks_done = 0;
	acg_note_t notes[$], nt;
	localparam logic [10:0] RAT [16] = '{11'h040, 11'h080, 11'h0c0, 11'h100, 11'h180, 11'h200,
		11'h300, 11'h400, 11'h580, 11'h600, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000};
	localparam logic [16:0] RT [16] = '{17'h01f40, 17'h02b11, 17'h02ee0, 17'h03e80, 17'h05622,
		17'h05dc0, 17'h07d00, 17'h0ac44, 17'h0bb80, 17'h15888, 17'h17700, 17'h0, 17'h0, 17'h0,
		17'h0, 17'h0};
	localparam logic [6:0] OFS [8] = '{`ACG_OFS_DIVIDERS, `ACG_OFS_RATE, `ACG_OFS_SOURCE,
		`ACG_OFS_LOOP_EN, `ACG_OFS_LOOP_DIV, `ACG_OFS_LOOP_FRAC, `ACG_OFS_LOOP_INT, `ACG_OFS_LOOP_REF};
	localparam logic [15:0] RST [8] = '{`ACG_RST_DIVIDERS, `ACG_RST_RATE, `ACG_RST_SOURCE,
		`ACG_RST_LOOP_EN, `ACG_RST_LOOP_DIV, `ACG_RST_LOOP_FRAC, `ACG_RST_LOOP_INT, `ACG_RST_LOOP_REF};
	localparam logic [15:0] MSK [8] = '{`ACG_MSK_DIVIDERS, `ACG_MSK_RATE, `ACG_MSK_SOURCE,
		`ACG_MSK_LOOP_EN, `ACG_MSK_LOOP_DIV, `ACG_MSK_LOOP_FRAC, `ACG_MSK_LOOP_INT, `ACG_MSK_LOOP_REF};
	localparam int OPN [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
	localparam int RP [4] = '{8, 6, 32, 1};
	wire logic [4:0] clks = {loop_reference, mclk_out, timeout_clock, processing_clock, system_clock};
	// short counts keep the timeout and reference-loss waits within a quick run
	acg_top #(.TO_PERIOD(16), .REF_LOSS_CYCLES(32)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .mclk_in(mclk_in), .bclk_in(bclk_in), .lrclk_in(lrclk_in),
		.fll_clk_in(fll_clk_in), .system_clock(system_clock), .processing_clock(processing_clock),
		.timeout_clock(timeout_clock), .mclk_out(mclk_out), .mclk_out_en(mclk_out_en),
		.loop_reference(loop_reference), .loop_enable_out(loop_enable_out),
		.loop_running(loop_running), .loop_multiplier_integer(loop_multiplier_integer),
		.loop_multiplier_fraction(loop_multiplier_fraction), .loop_ratio_value(loop_ratio_value),
		.loop_output_divide(loop_output_divide), .loop_control_divide(loop_control_divide),
		.loop_error_gain_value(loop_error_gain_value), .sysclk_ratio_value(sysclk_ratio_value),
		.sample_rate_hz(sample_rate_hz), .sample_rate_reserved(sample_rate_reserved));
	acg_ref_model u_ref (.clk(clk), .stop(stop), .mclk_out(mclk_out), .mclk_out_en(mclk_out_en),
		.mclk_in(mclk_in), .bclk_in(bclk_in), .lrclk_in(lrclk_in), .fll_clk_in(fll_clk_in));
	always #4 clk = ~clk;
	// ****************************************
	// scoreboard: oldest note against the outputs
	// ****************************************
	function automatic logic [16:0] pick(input logic [3:0] id);
		case (id)
			4'h0: pick = {1'b0, reg_rdata};
			4'h1: pick = {6'h00, sysclk_ratio_value};
			4'h2: pick = sample_rate_hz;
			4'h3: pick = {16'h0000, sample_rate_reserved};
			4'h4: pick = {8'h00, loop_output_divide};
			4'h5: pick = {13'h0000, loop_control_divide};
			4'h6: pick = {12'h000, loop_ratio_value};
			4'h7: pick = {8'h00, loop_error_gain_value};
			4'h8: pick = {7'h00, loop_multiplier_integer};
			4'h9: pick = {1'b0, loop_multiplier_fraction};
			4'ha: pick = {16'h0000, mclk_out_en};
			4'hb: pick = {16'h0000, loop_running};
			4'hc: pick = {16'h0000, loop_enable_out};
			4'hd: pick = {16'h0000, timeout_clock};
			default: pick = {16'h0000, in_range};
		endcase
	endfunction
	always @(posedge clk) pend <= note_req;
	always @(negedge clk) begin
		if (pend) begin
			nt = notes.pop_front();
			`CHK(pick(nt.id), nt.exp)
		end
	end
	// ****************************************
	// drivers, all moved on the falling edge
	// ****************************************
	task automatic results();
		// let the last pending note reach the scoreboard before the verdict
		repeat (2) @(negedge clk);
		if (failures == 0 && checks_done > 0 && notes.size() == 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic note(input logic [3:0] id, input logic [16:0] e);
		@(negedge clk);
		notes.push_back({id, e});
		note_req = 1'b1;
		@(negedge clk);
		note_req = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		notes.push_back({4'h0, 1'b0, e});
		note_req = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		note_req = 1'b0;
	endtask
	// counts rising levels of one derived clock; range allows a cycle of edge slip
	task automatic win(input int sel, input int n, input int lo, input int hi);
		int cnt;
		logic p;
		cnt = 0;
		p = 1'b1;
		repeat (n) begin
			@(negedge clk);
			if (clks[sel] === 1'b1 && p === 1'b0)
				cnt++;
			p = clks[sel];
		end
		in_range = cnt >= lo && cnt <= hi;
		note(4'hf, 17'h00001);
	endtask
	task automatic wait_run(input logic v);
		int k;
		for (k = 0; k < 300 && loop_running !== v; k++)
			@(negedge clk);
		if (loop_running !== v) begin
			failures++;
			results();
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int i, s, e;
		logic [15:0] r;
		void'($urandom(32'h7759));
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		note(4'h1, 17'h00100);
		note(4'h2, 17'h0bb80);
		for (i = 0; i < 8; i++) begin
			rd(OFS[i], RST[i]);
			wr(OFS[i], 16'hffff);
			rd(OFS[i], MSK[i]);
			wr(OFS[i], RST[i]);
		end
		wr(7'h0f, 16'hffff);
		rd(7'h0f, 16'h0000);
		ce = 1'b0;
		wr(`ACG_OFS_LOOP_FRAC, 16'h1234);
		ce = 1'b1;
		rd(`ACG_OFS_LOOP_FRAC, 16'h0000);
		for (i = 0; i < 16; i++) begin
			wr(`ACG_OFS_RATE, {8'h00, i[3:0], i[3:0]});
			note(4'h1, {6'h00, RAT[i]});
			note(4'h2, RT[i]);
			note(4'h3, {16'h0000, i > 10});
		end
		for (i = 0; i < 8; i++) begin
			wr(`ACG_OFS_LOOP_DIV, {5'h00, i[2:0], 1'b0, i[2:0], 1'b0, i[2:0]});
			note(4'h4, 17'(2 << i));
			note(4'h5, 17'(i + 1));
			note(4'h6, 17'(i < 4 ? 1 << i : 16));
		end
		for (i = 0; i < 16; i++) begin
			r = 16'($urandom);
			wr(`ACG_OFS_LOOP_INT, {1'b0, r[9:0], 1'b0, i[3:0]});
			note(4'h7, 17'(i < 9 ? 1 << i : 256));
			note(4'h8, {7'h00, r[9:0]});
		end
		r = 16'($urandom);
		wr(`ACG_OFS_LOOP_FRAC, r);
		note(4'h9, 17'h00000);
		wr(`ACG_OFS_LOOP_EN, 16'h0004);
		note(4'h9, {1'b0, r});
		wr(`ACG_OFS_LOOP_EN, 16'h0000);
		// legal setting: 12 MHz class reference, N.K 8.25, 99 MHz oscillator, 12.4 MHz out
		wr(`ACG_OFS_LOOP_DIV, 16'h0200);
		wr(`ACG_OFS_LOOP_INT, 16'h0100);
		wr(`ACG_OFS_LOOP_FRAC, 16'h4000);
		wr(`ACG_OFS_LOOP_EN, 16'h0005);
		note(4'h4, 17'h00008);
		note(4'h6, 17'h00001);
		note(4'h8, 17'h00008);
		note(4'h9, 17'h04000);
		wr(`ACG_OFS_LOOP_EN, 16'h0000);
		// system clock off before every source change
		win(0, 240, 0, 1);
		wr(`ACG_OFS_SOURCE, 16'h0003);
		win(0, 240, 39, 41);
		win(1, 240, 39, 41);
		wr(`ACG_OFS_SOURCE, 16'h0000);
		wr(`ACG_OFS_SOURCE, 16'h2001);
		win(0, 240, 59, 61);
		win(1, 240, 0, 1);
		for (s = 0; s < 4; s++) begin
			wr(`ACG_OFS_DIVIDERS, 16'(s << 8));
			wr(`ACG_OFS_SOURCE, 16'h2005);
			win(2, 512, (8 << s) - 1, (8 << s) + 1);
		end
		wr(`ACG_OFS_SOURCE, 16'h2001);
		win(2, 512, 0, 0);
		note(4'hd, 17'h00000);
		// output clock only while the pin is not a clock input
		wr(`ACG_OFS_SOURCE, 16'h2021);
		for (i = 0; i < 8; i++) begin
			wr(`ACG_OFS_DIVIDERS, {3'h0, i[2:0], 10'h000});
			note(4'ha, 17'h00001);
			win(3, 384, 96 / OPN[i] - 1, 96 / OPN[i] + 1);
		end
		wr(`ACG_OFS_SOURCE, 16'h2001);
		note(4'ha, 17'h00000);
		for (s = 0; s < 4; s++) begin
			for (i = 0; i < 4; i++) begin
				wr(`ACG_OFS_LOOP_EN, 16'h0000);
				wr(`ACG_OFS_LOOP_REF, {11'h000, i[1:0], 1'b0, s[1:0]});
				wr(`ACG_OFS_LOOP_EN, 16'h0001);
				e = s == 3 ? 0 : 768 / (RP[s] << i);
				win(4, 768, e == 0 ? 0 : e - 1, e + 1);
			end
		end
		wr(`ACG_OFS_LOOP_EN, 16'h0000);
		wr(`ACG_OFS_LOOP_REF, 16'h0000);
		wr(`ACG_OFS_LOOP_EN, 16'h0001);
		wait_run(1'b1);
		note(4'hc, 17'h00001);
		stop = 1'b1;
		wait_run(1'b0);
		note(4'hb, 17'h00000);
		stop = 1'b0;
		wr(`ACG_OFS_LOOP_EN, 16'h0000);
		wr(`ACG_OFS_LOOP_EN, 16'h0009);
		wait_run(1'b1);
		stop = 1'b1;
		repeat (100) @(negedge clk);
		note(4'hb, 17'h00001);
		stop = 1'b0;
		wr(`ACG_OFS_LOOP_EN, 16'h0000);
		note(4'hc, 17'h00000);
		results();
	end
endmodule
`default_nettype wire
